/* batch_sched.sv */
/*
  Batch transaction sequencer: register file, descriptor walker, frame
  timer, suspend and power-save control, interrupt line.
  Assumes a link engine that runs each handed transaction and reports once.
*/
// The Wishbone interface to the registers and the register offsets were left to the implementer.
// Function
// R1 - A batch holds up to sixteen transactions of any speed, endpoint or type.
// R2 - One command dispatches the batch; one completion interrupt after all.
// R3 - Selected descriptors run in order from the lowest index upward.
// R4 - Several batches may be dispatched and completed within one frame.
// R5 - Unfinished work waits and resumes after the next generated start-of-frame.
// R6 - A programmed overhead limit caps transactions executed per frame.
// R7 - Software allocates and fully programs descriptors before dispatch.
// R8 - 2048 bytes shared buffer; start and length come from each descriptor.
// R9 - Software allocates a big enough buffer unless the packet is empty.
// R10 - Software writes outgoing payload before dispatching the batch.
// R11 - Received IN data lands in the buffer only during its transaction.
// R12 - Processor and engine access registers and memories concurrently.
// R13 - Selection register plus one command write switches to another cluster.
// R14 - Software keeps one isochronous transaction per frame, under 950 us.
// R15 - Active-low interrupt from port change, done, stop, error and SOF.
// R16 - Selectable stop after success, failure or NAK of a transaction.
// R17 - Each of the five interrupt sources has its own mask.
// R18 - PLL derives internal clocks from one 6 MHz reference.
// R19 - Suspend halts all bus activity, start-of-frame included.
// R20 - Suspend ends on a software resume or a remote wakeup.
// R21 - Power-save stops internal clocks and disables the PLL.
// R22 - Power-save ends only by master or power-on reset.
// R23 - Descriptor memory is sixteen descriptors of sixteen bytes.
// R24 - Descriptor holds address, endpoint, type, buffer, count, iso, speed, toggle.
// R25 - Completion writes status, and for IN the toggle and byte count.
// R26 - Batch-in-progress clears when a batch completes or stops.
`timescale 1ns/1ps
module batch_sched #(
  parameter int FRAME_CYC = sched_pkg::FRAME_CYC_DEF,
  parameter int RESUME_CYC = sched_pkg::RESUME_CYC_DEF,
  parameter int USBRST_CYC = sched_pkg::USBRST_CYC_DEF
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [13:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Link engine
  output sched_pkg::txn_req_t txn_req,
  output logic txn_valid,
  input wire logic txn_ready,
  input wire logic txn_done,
  input wire sched_pkg::txn_res_t txn_res,
  input wire sched_pkg::buf_port_t link_buf,
  output logic [7:0] link_rdata,
  // Root hub and pins
  input wire logic port_change,
  input wire logic hc_error,
  input wire logic remote_wake,
  // Status outputs
  output logic irq_n,
  output logic sof_pulse,
  output logic usb_suspend,
  output logic usb_resume,
  output logic usb_reset,
  output logic pll_en,
  output logic clk_run
);
  import sched_pkg::*;

  typedef enum {HC_IDLE, HC_USBRST, HC_OPER, HC_SUSP, HC_RESUME, HC_PSAVE} hcfs_t;
  typedef enum {B_IDLE, B_PICK, B_FETCH, B_REQ, B_WAIT, B_WB, B_HOLD} bst_t;

  hcfs_t hcfs_r;
  bst_t bst_r;
  logic stage_r, ack_r;
  logic [31:0] dat_r, rd_mux;
  logic [11:0] idx;
  logic wr_ack;
  logic [15:0] sel_r, done_r, pend_r;
  logic [7:0] ovh_r, ftx_r;
  logic [4:0] ien_r, istat_r, ev;
  logic [2:0] stop_r;
  logic [15:0] fc_r;
  logic [10:0] fnum_r;
  logic [31:0] tm_r;
  logic [3:0] idx_r, k_r;
  logic [7:0] d_r [0:7];
  txn_res_t res_r;
  logic [2:0] rw_s;
  logic rw_r, rw_q, rw_rise;
  logic [7:0] cmd;
  logic cmd_ok, srst, wb_end, last, stop_hit, done_ev, stop_ev, batch_on;
  logic [7:0] da_rd, db_rd, db_wd, ba_rd;
  logic da_we, ba_we, bb_we;
  logic [7:0] db_addr;

  function automatic logic [3:0] lowest(input logic [15:0] v);
    lowest = 4'h0;
    for (int i = NUM_DESC - 1; i >= 0; i--)
      if (v[i])
        lowest = 4'(i);
  endfunction : lowest

  // Bus handshake: stage then ack, so read data come from a flop
  assign idx = wb_adr_i[13:2];
  assign wr_ack = ack_r & wb_we_i;
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      stage_r <= 1'b0;
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end
    else
    begin
      stage_r <= wb_cyc_i & wb_stb_i & ~stage_r & ~ack_r;
      ack_r <= stage_r;
      if (stage_r)
        dat_r <= rd_mux;
    end
  end
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // Read mux; reserved space reads zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (idx)
      REG_CTRL: rd_mux[4:0] = {hcfs_r == HC_USBRST, hcfs_r == HC_SUSP,
                               hcfs_r == HC_RESUME, hcfs_r == HC_OPER, batch_on};
      REG_SEL: rd_mux[15:0] = sel_r;
      REG_DONE: rd_mux[15:0] = done_r;
      REG_ISTAT: rd_mux[4:0] = istat_r;
      REG_IEN: rd_mux[4:0] = ien_r;
      REG_FMREM: rd_mux[15:0] = 16'(FRAME_CYC - 1) - fc_r;
      REG_FMNUM: rd_mux[10:0] = fnum_r;
      REG_OVH: rd_mux[7:0] = ovh_r;
      REG_STOP: rd_mux[2:0] = stop_r;
      default:
        if (idx[11:8] == DESC_PAGE)
          rd_mux[7:0] = da_rd;
        else if (idx[11])
          rd_mux[7:0] = ba_rd;
    endcase
  end

  // Command decode: one bit only, never out of power-save
  assign cmd = wb_dat_i[7:0];
  assign cmd_ok = wr_ack & (idx == REG_CTRL) & wb_sel_i[0] & $onehot(cmd)
                  & (hcfs_r != HC_PSAVE); // R22
  assign srst = cmd_ok & cmd[CMD_SRST];

  // Plain control registers
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      sel_r <= SEL_RST;
      ovh_r <= OVH_RST;
      ien_r <= IEN_RST;
      stop_r <= STOP_RST;
    end
    else if (wr_ack)
    begin
      if (idx == REG_SEL && wb_sel_i[0])
        sel_r[7:0] <= wb_dat_i[7:0]; // R13
      if (idx == REG_SEL && wb_sel_i[1])
        sel_r[15:8] <= wb_dat_i[15:8]; // R13
      if (idx == REG_OVH && wb_sel_i[0])
        ovh_r <= wb_dat_i[7:0];
      if (idx == REG_IEN && wb_sel_i[0])
        ien_r <= wb_dat_i[4:0]; // R17
      if (idx == REG_STOP && wb_sel_i[0])
        stop_r <= wb_dat_i[2:0]; // R16
    end
  end

  // Functional state; only reset leaves power-save
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      hcfs_r <= HC_IDLE;
      tm_r <= 32'h0000_0000;
    end
    else
    begin
      tm_r <= tm_r + 32'h0000_0001;
      case (hcfs_r)
        HC_USBRST:
          if (tm_r == 32'(USBRST_CYC - 1))
            hcfs_r <= HC_IDLE;
        HC_RESUME:
          if (tm_r == 32'(RESUME_CYC - 1))
            hcfs_r <= HC_OPER;
        HC_SUSP:
          if (rw_rise)
          begin
            hcfs_r <= HC_RESUME; // R20
            tm_r <= 32'h0000_0000;
          end
        HC_PSAVE: hcfs_r <= HC_PSAVE; // R22
        default: ;
      endcase
      if (cmd_ok)
      begin
        tm_r <= 32'h0000_0000;
        if (cmd[CMD_PSAVE])
          hcfs_r <= HC_PSAVE; // R21
        else if (srst)
          hcfs_r <= HC_IDLE;
        else if (cmd[CMD_USBRST] && hcfs_r != HC_RESUME)
          hcfs_r <= HC_USBRST;
        else if (cmd[CMD_SUSP] && hcfs_r == HC_OPER)
          hcfs_r <= HC_SUSP; // R19
        else if (cmd[CMD_RES] && hcfs_r == HC_SUSP)
          hcfs_r <= HC_RESUME; // R20
        else if (cmd[CMD_OPER] && hcfs_r == HC_IDLE)
          hcfs_r <= HC_OPER;
      end
    end
  end

  // Clock control; the analog PLL itself sits outside this logic
  assign pll_en = hcfs_r != HC_PSAVE; // R18 R21
  assign clk_run = hcfs_r != HC_PSAVE; // R21
  assign usb_suspend = hcfs_r == HC_SUSP;
  assign usb_resume = hcfs_r == HC_RESUME;
  assign usb_reset = hcfs_r == HC_USBRST;

  // Remote wakeup pin: three flops, change once last two agree
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rw_s <= 3'h0;
      rw_r <= 1'b0;
      rw_q <= 1'b0;
    end
    else
    begin
      rw_s <= {rw_s[1:0], remote_wake};
      if (rw_s[1] == rw_s[2])
        rw_r <= rw_s[2];
      rw_q <= rw_r;
    end
  end
  assign rw_rise = rw_r & ~rw_q;

  // Frame timer runs only when operational, so suspend stops SOF
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      fc_r <= 16'h0000;
      fnum_r <= 11'h000;
    end
    else if (hcfs_r != HC_OPER)
      fc_r <= 16'h0000; // R19
    else if (fc_r == 16'(FRAME_CYC - 1))
    begin
      fc_r <= 16'h0000;
      fnum_r <= fnum_r + 11'h001;
    end
    else
      fc_r <= fc_r + 16'h0001;
  end
  assign sof_pulse = (hcfs_r == HC_OPER) && (fc_r == 16'(FRAME_CYC - 1)); // R19

  // Writeback step ends the transaction; decide stop or finish
  assign wb_end = (bst_r == B_WB) && (k_r == 4'h3);
  assign last = (pend_r & ~(16'h0001 << idx_r)) == 16'h0000;
  assign stop_hit = (stop_r[STOP_ACK] && res_r.status == ST_ACK)
    || (stop_r[STOP_FAIL] && (res_r.status == ST_STALL || res_r.status == ST_TMO
        || res_r.status == ST_ERR))
    || (stop_r[STOP_NAK] && res_r.status == ST_NAK); // R16
  assign done_ev = wb_end & last & ~stop_hit; // R2
  assign stop_ev = wb_end & stop_hit; // R16
  assign batch_on = bst_r != B_IDLE; // R26

  // Batch walker
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      bst_r <= B_IDLE;
    else if (srst || (hcfs_r != HC_OPER && hcfs_r != HC_SUSP && hcfs_r != HC_RESUME))
      bst_r <= B_IDLE;
    else
      case (bst_r)
        B_IDLE:
          if (cmd_ok && cmd[CMD_BATCH] && hcfs_r == HC_OPER && sel_r != 16'h0000)
            bst_r <= B_PICK; // R2 R4
        B_PICK:
          if (hcfs_r != HC_OPER || (ovh_r != 8'h00 && ftx_r >= ovh_r))
            bst_r <= B_HOLD; // R5 R6
          else
            bst_r <= B_FETCH;
        B_FETCH:
          if (k_r == D_LAST_CFG)
            bst_r <= B_REQ;
        B_REQ:
          if (txn_valid && txn_ready)
            bst_r <= B_WAIT;
        B_WAIT:
          if (txn_done)
            bst_r <= B_WB;
        B_WB:
          if (wb_end)
            bst_r <= (last || stop_hit) ? B_IDLE : B_PICK; // R26
        B_HOLD:
          if (sof_pulse)
            bst_r <= B_PICK; // R5
        default: bst_r <= B_IDLE;
      endcase
  end

  // Pending set, done bits and current descriptor
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      pend_r <= 16'h0000;
      done_r <= 16'h0000;
      idx_r <= 4'h0;
    end
    else if (bst_r == B_IDLE && cmd_ok && cmd[CMD_BATCH])
    begin
      pend_r <= sel_r; // R1 R13
      done_r <= 16'h0000;
    end
    else if (bst_r == B_PICK)
      idx_r <= lowest(pend_r); // R3
    else if (wb_end)
    begin
      pend_r <= stop_hit ? 16'h0000 : pend_r & ~(16'h0001 << idx_r);
      done_r <= done_r | (16'h0001 << idx_r);
    end
  end

  // Step counter and transactions spent in this frame
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      k_r <= 4'h0;
      ftx_r <= 8'h00;
    end
    else
    begin
      k_r <= (bst_r == B_FETCH || bst_r == B_WB) ? k_r + 4'h1 : 4'h0;
      if (sof_pulse)
        ftx_r <= 8'h00; // R6
      else if (wb_end && ftx_r != 8'hFF)
        ftx_r <= ftx_r + 8'h01; // R6
    end
  end

  // Descriptor fetch: read data trail the address by one cycle
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < 8; i++)
        d_r[i] <= 8'h00;
      res_r <= '0;
    end
    else
    begin
      if (bst_r == B_FETCH && k_r != 4'h0)
        d_r[3'(k_r - 4'h1)] <= db_rd; // R24
      if (bst_r == B_WAIT && txn_done)
        res_r <= txn_res;
    end
  end

  // Transaction handed to the link engine
  // Request held back while suspended, so a fetched descriptor waits for resume
  assign txn_valid = (bst_r == B_REQ) && (hcfs_r == HC_OPER); // R19
  assign txn_req.dev_addr = d_r[0][6:0]; // R24
  assign txn_req.endpoint = d_r[1][3:0];
  assign txn_req.kind = d_r[1][5:4];
  assign txn_req.iso = d_r[1][6];
  assign txn_req.low_speed = d_r[1][7];
  assign txn_req.buf_start = {d_r[3][2:0], d_r[2]}; // R8
  assign txn_req.length = {d_r[5][1:0], d_r[4]}; // R8
  assign txn_req.toggle = d_r[6][0];

  // Writeback of status, toggle and count into the descriptor
  always_comb
  begin
    case (k_r[1:0])
      2'h0: db_wd = {5'h00, res_r.status}; // R25
      2'h1: db_wd = {7'h00, res_r.toggle}; // R25
      2'h2: db_wd = res_r.count[7:0]; // R25
      default: db_wd = {6'h00, res_r.count[9:8]};
    endcase
  end
  assign db_addr = (bst_r == B_WB) ? {idx_r, D_STAT + k_r} : {idx_r, k_r};

  // Bus port A and engine port B run side by side
  assign da_we = wr_ack & wb_sel_i[0] & (idx[11:8] == DESC_PAGE); // R12
  assign ba_we = wr_ack & wb_sel_i[0] & idx[11]; // R12
  assign bb_we = link_buf.en & link_buf.we & (bst_r == B_WAIT); // R11

  dp_ram #(.AW(DESC_AW), .DW(8)) desc_mem (
    .clock(clock),
    .a_we(da_we),
    .a_addr(idx[7:0]),
    .a_wdata(wb_dat_i[7:0]),
    .a_rdata(da_rd),
    .b_we(bst_r == B_WB),
    .b_addr(db_addr),
    .b_wdata(db_wd),
    .b_rdata(db_rd)
  ); // R23

  dp_ram #(.AW(BUF_AW), .DW(8)) buf_mem (
    .clock(clock),
    .a_we(ba_we),
    .a_addr(idx[10:0]),
    .a_wdata(wb_dat_i[7:0]),
    .a_rdata(ba_rd),
    .b_we(bb_we),
    .b_addr(link_buf.addr),
    .b_wdata(link_buf.wdata),
    .b_rdata(link_rdata)
  ); // R8

  // Interrupt status: set wins over write-one-to-clear
  assign ev = {sof_pulse, hc_error, stop_ev, done_ev, port_change}; // R15
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      istat_r <= 5'h00;
    else if (srst)
      istat_r <= ev;
    else if (wr_ack && idx == REG_ISTAT && wb_sel_i[0])
      istat_r <= (istat_r & ~wb_dat_i[4:0]) | ev;
    else
      istat_r <= istat_r | ev; // R15
  end
  assign irq_n = ~|(istat_r & ien_r); // R15 R17

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  a_ack_latency: assert property ($rose(wb_cyc_i & wb_stb_i) |-> ##2 wb_ack_o) // R12
    else $error("bus ack not two cycles after request");
  a_dispatch_load: assert property ((bst_r == B_IDLE) ##1 (bst_r == B_PICK)
    |-> pend_r == $past(sel_r)) // R1
    else $error("pending set differs from selection");
  a_lowest_first: assert property ((bst_r == B_FETCH)
    |-> (pend_r & ((16'h0001 << idx_r) - 16'h0001)) == 16'h0000) // R3
    else $error("lower descriptor still pending");
  a_frame_cap: assert property ((bst_r == B_REQ && ovh_r != 8'h00) |-> ftx_r < ovh_r) // R6
    else $error("frame transaction limit exceeded");
  a_hold_sof: assert property ((bst_r == B_HOLD && sof_pulse) |=> bst_r == B_PICK) // R5
    else $error("held batch not resumed at SOF");
  a_done_irq: assert property (done_ev |=> istat_r[INT_DONE] && bst_r == B_IDLE) // R2
    else $error("batch completion not flagged");
  a_stop_end: assert property (stop_ev |=> !batch_on && pend_r == 16'h0000) // R26
    else $error("stopped batch still in progress");
  a_susp_quiet: assert property ((hcfs_r == HC_SUSP) |-> !sof_pulse && !txn_valid) // R19
    else $error("bus activity during suspend");
  a_wake_resume: assert property ((hcfs_r == HC_SUSP && rw_rise) |=> hcfs_r == HC_RESUME) // R20
    else $error("remote wakeup ignored");
  a_psave_hold: assert property ((hcfs_r == HC_PSAVE) |=> hcfs_r == HC_PSAVE && !pll_en) // R22
    else $error("power-save left without reset");
  a_in_gate: assert property (bb_we |-> $past(bst_r) == B_WAIT || bst_r == B_WAIT) // R11
    else $error("buffer write outside transaction");

  c_batch_done: cover property (done_ev);
  c_batch_stop: cover property (stop_ev);
  c_spill_over: cover property ((bst_r == B_HOLD) ##1 sof_pulse);

endmodule : batch_sched

/* sched_pkg.sv */
/*
  Shared constants and types for the batch transaction sequencer.
  Assumes a 10 MHz core clock and a 32-bit classic Wishbone register bus.
*/
package sched_pkg;

  // Register word indices; byte address is four times the index
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_SEL = 12'h002;
  localparam logic [11:0] REG_DONE = 12'h004;
  localparam logic [11:0] REG_ISTAT = 12'h006;
  localparam logic [11:0] REG_IEN = 12'h007;
  localparam logic [11:0] REG_FMREM = 12'h00A;
  localparam logic [11:0] REG_FMNUM = 12'h00C;
  localparam logic [11:0] REG_OVH = 12'h00E;
  localparam logic [11:0] REG_STOP = 12'h010;
  localparam logic [3:0] DESC_PAGE = 4'h4;

  // Command bits of the system command register
  localparam int CMD_PSAVE = 7;
  localparam int CMD_SRST = 5;
  localparam int CMD_USBRST = 4;
  localparam int CMD_SUSP = 3;
  localparam int CMD_RES = 2;
  localparam int CMD_OPER = 1;
  localparam int CMD_BATCH = 0;

  // Interrupt source bits
  localparam int INT_PORT = 0;
  localparam int INT_DONE = 1;
  localparam int INT_STOP = 2;
  localparam int INT_HCERR = 3;
  localparam int INT_SOF = 4;
  localparam int NUM_INT = 5;

  // Stop-select bits
  localparam int STOP_ACK = 0;
  localparam int STOP_FAIL = 1;
  localparam int STOP_NAK = 2;

  // Memory sizes and descriptor layout
  localparam int NUM_DESC = 16;
  localparam int DESC_AW = 8;
  localparam int BUF_AW = 11;
  localparam logic [3:0] D_STAT = 4'h8;
  localparam logic [3:0] D_LAST_CFG = 4'h7;

  // Completion status codes
  localparam logic [2:0] ST_ACK = 3'h0;
  localparam logic [2:0] ST_NAK = 3'h1;
  localparam logic [2:0] ST_STALL = 3'h2;
  localparam logic [2:0] ST_TMO = 3'h3;
  localparam logic [2:0] ST_ERR = 3'h4;
  localparam logic [2:0] ST_OVF = 3'h5;

  // Reset values
  localparam logic [15:0] SEL_RST = 16'h0000;
  localparam logic [7:0] OVH_RST = 8'h00;
  localparam logic [4:0] IEN_RST = 5'h00;
  localparam logic [2:0] STOP_RST = 3'h0;

  // Timing
  localparam int CLK_NS = 100;
  localparam int FRAME_NS = 1000000;
  localparam int RESUME_NS = 20000000;
  localparam int USBRST_NS = 10000000;
  localparam int FRAME_CYC_DEF = FRAME_NS / CLK_NS;
  localparam int RESUME_CYC_DEF = (RESUME_NS + CLK_NS - 1) / CLK_NS;
  localparam int USBRST_CYC_DEF = (USBRST_NS + CLK_NS - 1) / CLK_NS;

  // One transaction handed to the link engine
  typedef struct packed {
    logic [6:0] dev_addr;
    logic [3:0] endpoint;
    logic [1:0] kind;
    logic iso;
    logic low_speed;
    logic toggle;
    logic [10:0] buf_start;
    logic [9:0] length;
  } txn_req_t;

  // Outcome reported by the link engine
  typedef struct packed {
    logic [2:0] status;
    logic toggle;
    logic [9:0] count;
  } txn_res_t;

  // Link engine byte access to shared buffer memory
  typedef struct packed {
    logic en;
    logic we;
    logic [10:0] addr;
    logic [7:0] wdata;
  } buf_port_t;

endpackage : sched_pkg

/* dp_ram.sv */
/*
  Dual-port byte memory with registered read data on both ports.
  Assumes one clock; a same-address write collision lets port B win.
*/
`timescale 1ns/1ps
module dp_ram #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  // Clock
  input wire logic clock,
  // Port A
  input wire logic a_we,
  input wire logic [AW-1:0] a_addr,
  input wire logic [DW-1:0] a_wdata,
  output logic [DW-1:0] a_rdata,
  // Port B
  input wire logic b_we,
  input wire logic [AW-1:0] b_addr,
  input wire logic [DW-1:0] b_wdata,
  output logic [DW-1:0] b_rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Writes; B last so the engine wins a collision
  always_ff @(posedge clock)
  begin
    if (a_we)
      mem[a_addr] <= a_wdata;
    if (b_we)
      mem[b_addr] <= b_wdata;
  end

  // Registered reads, no reset needed for storage
  always_ff @(posedge clock)
  begin
    a_rdata <= mem[a_addr];
    b_rdata <= mem[b_addr];
  end

endmodule : dp_ram

/* link_model.sv */
/*
  Link engine stand-in: takes one request at a time, reports a few cycles later.
  Assumes the sequencer holds txn_valid and txn_req until txn_ready is seen.
*/
`timescale 1ns/1ps
module link_model (
  // Clock
  input wire logic clock,
  // Sequencer side
  input wire logic txn_valid,
  input wire sched_pkg::txn_req_t txn_req,
  output logic txn_ready,
  output logic txn_done,
  output sched_pkg::txn_res_t txn_res,
  output sched_pkg::buf_port_t link_buf,
  // Outcome chosen by the bench
  input wire logic [2:0] res_status
);
  import sched_pkg::*;
  int cnt = 0;
  // Buffer port idle; this model moves no payload
  initial
  begin
    txn_ready = 1'b0;
    txn_done = 1'b0;
    txn_res = '0;
    link_buf = '0;
  end
  // Ready a cycle late so the request must be held, done four cycles on
  always @(posedge clock)
  begin
    txn_done <= 1'b0;
    txn_ready <= txn_valid && !txn_ready && cnt == 0;
    if (txn_valid && txn_ready)
      cnt <= 4;
    else if (cnt > 1)
      cnt <= cnt - 1;
    else if (cnt == 1)
    begin
      cnt <= 0;
      txn_done <= 1'b1;
      txn_res <= {res_status, 1'b1, 10'h000};
    end
  end
endmodule : link_model

/* tb_top.sv */
/*
  Testbench for the batch sequencer: Wishbone tasks, batch scenarios, power states.
  Assumes link_model on the link side and shortened frame and resume counts.
*/
`timescale 1ns/1ps
module tb_top;
  import sched_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [13:0] adr = 14'h0000;
  logic [3:0] sel = 4'h3;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic port_change = 1'b0;
  logic hc_error = 1'b0;
  logic remote_wake = 1'b0;
  logic [2:0] res_st = ST_ACK;
  logic [2:0] stat [3] = '{ST_ACK, ST_STALL, ST_NAK};
  txn_req_t txn_req;
  txn_res_t txn_res;
  buf_port_t link_buf;
  logic txn_valid, txn_ready, txn_done, irq_n, sof_pulse, pll_en, clk_run;
  logic usb_suspend, usb_resume, usb_reset;
  logic [6:0] taken [$];
  int frames [$];
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  int sofs = 0;
  int k;

  batch_sched #(.FRAME_CYC(200), .RESUME_CYC(50), .USBRST_CYC(40)) i_dut (
    .clock(clock), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .txn_req(txn_req), .txn_valid(txn_valid), .txn_ready(txn_ready),
    .txn_done(txn_done), .txn_res(txn_res), .link_buf(link_buf), .link_rdata(),
    .port_change(port_change), .hc_error(hc_error), .remote_wake(remote_wake),
    .irq_n(irq_n), .sof_pulse(sof_pulse), .usb_suspend(usb_suspend),
    .usb_resume(usb_resume), .usb_reset(usb_reset), .pll_en(pll_en), .clk_run(clk_run));
  link_model i_link (.clock(clock), .txn_valid(txn_valid), .txn_req(txn_req),
    .txn_ready(txn_ready), .txn_done(txn_done), .txn_res(txn_res),
    .link_buf(link_buf), .res_status(res_st));

  // 10 MHz clock
  initial
  begin
    forever #50 clock = ~clock;
  end

  task automatic end_of_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Classic cycle held until ack; global timeout ends a hang
  task automatic wb(input logic w, input logic [11:0] i, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    dat <= d;
    do
      @(posedge clock);
    while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic wr(input logic [11:0] i, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, i, d, q);
  endtask : wr

  task automatic rd(input logic [11:0] i, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] q;
    wb(1'b0, i, 32'h0, q);
    chk(q & m, e);
  endtask : rd

  // Dispatch, await the interrupt, then check order, status and done bits
  task automatic batch(input logic [15:0] s, input logic [31:0] ist, input logic [15:0] dn);
    int j;
    j = 0;
    taken.delete();
    frames.delete();
    wr(REG_ISTAT, 32'h1F);
    wr(REG_SEL, {16'h0, s});
    wr(REG_CTRL, 32'h01);
    while (irq_n !== 1'b0)
      @(posedge clock);
    rd(REG_ISTAT, ist, 32'h06);
    rd(REG_CTRL, 32'h02, 32'h1F);
    rd(REG_DONE, {16'h0, dn}, 32'hFFFF);
    for (int n = 0; n < 16; n++)
      if (dn[n])
      begin
        chk(32'(taken[j]), 32'(n + 16));
        j++;
      end
    chk(32'(taken.size()), 32'(j));
  endtask : batch

  // Log of accepted requests, frame count and timeout
  always @(posedge clock)
  begin
    cycles++;
    if (sof_pulse === 1'b1)
      sofs++;
    if (txn_valid === 1'b1 && txn_ready === 1'b1)
    begin
      taken.push_back(txn_req.dev_addr);
      frames.push_back(sofs);
    end
    if (cycles == 40000)
    begin
      fails++;
      end_of_test();
    end
  end

  initial
  begin
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    rd(REG_CTRL, 32'h0, 32'hFF);
    rd(REG_SEL, {16'h0, SEL_RST}, 32'hFFFFFFFF);
    rd(REG_IEN, {27'h0, IEN_RST}, 32'hFFFFFFFF);
    rd(REG_OVH, {24'h0, OVH_RST}, 32'hFFFFFFFF);
    rd(REG_STOP, {29'h0, STOP_RST}, 32'hFFFFFFFF);
    wr(12'h300, 32'hFF);
    rd(12'h300, 32'h0, 32'hFFFFFFFF);
    for (int n = 0; n < 16; n++)
    begin
      wr(12'h400 + 12'(n * 16), 32'(n + 16));
      wr(12'h404 + 12'(n * 16), 32'h04);
      wr(12'h800 + 12'(n * 4), 32'(n + 8'hA0));
    end
    rd(12'h83C, 32'hA0 + 32'h0F, 32'hFF);
    wr(REG_CTRL, 32'h02);
    rd(REG_CTRL, 32'h02, 32'h1F);
    wr(REG_IEN, 32'h06);
    batch(16'h0024, 32'h02, 16'h0024);
    batch(16'h0003, 32'h02, 16'h0003);
    batch(16'hFFFF, 32'h02, 16'hFFFF);
    chk(32'(frames[15] > frames[0]), 32'h1);
    rd(12'h428, {29'h0, ST_ACK}, 32'hFF);
    wr(REG_OVH, 32'h01);
    batch(16'h0024, 32'h02, 16'h0024);
    chk(32'(frames[1] > frames[0]), 32'h1);
    wr(REG_OVH, 32'h00);
    // Each stop condition ends the batch after its first transaction
    for (int m = 0; m < 3; m++)
    begin
      wr(REG_STOP, 32'(1 << m));
      res_st <= stat[m];
      batch(16'h0024, 32'h04, 16'h0004);
      rd(12'h428, {29'h0, stat[m]}, 32'hFF);
    end
    wr(REG_STOP, 32'h0);
    res_st <= ST_ACK;
    // Masking and clearing the pending stop source
    wr(REG_IEN, 32'h00);
    @(posedge clock);
    chk(32'(irq_n), 32'h1);
    wr(REG_IEN, 32'h0D);
    @(posedge clock);
    chk(32'(irq_n), 32'h0);
    wr(REG_ISTAT, 32'h04);
    @(posedge clock);
    chk(32'(irq_n), 32'h1);
    port_change <= 1'b1;
    @(posedge clock);
    port_change <= 1'b0;
    hc_error <= 1'b1;
    @(posedge clock);
    hc_error <= 1'b0;
    rd(REG_ISTAT, 32'h09, 32'h09);
    chk(32'(irq_n), 32'h0);
    wr(REG_IEN, 32'h00);
    // Suspend: no frames, then wake by pin and by command
    wr(REG_CTRL, 32'h08);
    @(posedge clock);
    k = sofs;
    repeat (300) @(posedge clock);
    chk(32'(sofs - k), 32'h0);
    chk(32'(usb_suspend), 32'h1);
    rd(REG_CTRL, 32'h08, 32'h1F);
    remote_wake <= 1'b1;
    repeat (60) @(posedge clock);
    remote_wake <= 1'b0;
    rd(REG_CTRL, 32'h02, 32'h1F);
    wr(REG_CTRL, 32'h08);
    wr(REG_CTRL, 32'h04);
    @(posedge clock);
    chk(32'(usb_resume), 32'h1);
    repeat (60) @(posedge clock);
    rd(REG_CTRL, 32'h02, 32'h1F);
    // USB reset runs out its count; soft reset clears pending status
    wr(REG_CTRL, 32'h10);
    @(posedge clock);
    chk(32'(usb_reset), 32'h1);
    repeat (45) @(posedge clock);
    rd(REG_CTRL, 32'h00, 32'h1F);
    wr(REG_CTRL, 32'h20);
    rd(REG_ISTAT, 32'h00, 32'h0F);
    // Power-save holds until reset
    wr(REG_CTRL, 32'h80);
    @(posedge clock);
    chk(32'({pll_en, clk_run}), 32'h0);
    wr(REG_CTRL, 32'h02);
    @(posedge clock);
    chk(32'({pll_en, clk_run}), 32'h0);
    rstn <= 1'b0;
    @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    chk(32'({pll_en, clk_run}), 32'h3);
    end_of_test();
  end
endmodule : tb_top
